/* flash_seq_pkg.sv */
// flash_seq_pkg: opcodes, wrap encodings and timing counts of the
// program / erase / wrap-setting sequencer.
// assumes a 100 MHz system clock; link clock comes from the host.
package flash_seq_pkg;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SET_WRAP    = 8'h77;
  localparam logic [7:0] OP_PAGE_PROG   = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG   = 8'h32;
  localparam logic [7:0] OP_SECTOR_ERS  = 8'h20;
  localparam logic [7:0] OP_SMALL_ERS   = 8'hd8 ^ 8'h8a;
  localparam logic [7:0] OP_LARGE_ERS   = 8'hd8;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W      = 32;
  localparam int PAGE_BYTES  = 256;
  localparam int MEM_AW      = 12;   // modelled array address width (bytes)
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [2:0] WRAP_RESET  = 3'h1;  // wrap_disable=1
  localparam int WRAP_DIS_BIT = 4;
  localparam int WRAP_LEN_HI  = 6;
  localparam int WRAP_LEN_LO  = 5;

  // ----------------------------------------------------------------
  // self-timed cycle lengths
  // ----------------------------------------------------------------
  localparam int CLK_MHZ                = 100;
  localparam int PAGE_PROG_TIME_US      = 700;
  localparam int SECTOR_ERASE_TIME_US   = 45000;
  localparam int SMALL_BLOCK_ERASE_TIME_US = 120000;
  localparam int LARGE_BLOCK_ERASE_TIME_US = 150000;
  localparam int PROG_CYCLES  = PAGE_PROG_TIME_US * CLK_MHZ;
  localparam int SECT_CYCLES  = SECTOR_ERASE_TIME_US * CLK_MHZ;
  localparam int SBLK_CYCLES  = SMALL_BLOCK_ERASE_TIME_US * CLK_MHZ;
  localparam int LBLK_CYCLES  = LARGE_BLOCK_ERASE_TIME_US * CLK_MHZ;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_WRAP, CMD_PROG, CMD_QPROG,
    CMD_SECT, CMD_SBLK, CMD_LBLK
  } cmd_type;

endpackage : flash_seq_pkg

/* flash_byte_mem.sv */
// flash_byte_mem: small byte array standing for the flash cells.
// assumes one write and one read per clock; read data is registered.
module flash_byte_mem (
  input  wire logic                              clock,
  input  wire logic                              wrEn,
  input  wire logic [flash_seq_pkg::MEM_AW-1:0]  wrAddr,
  input  wire logic [7:0]                        wrData,
  input  wire logic [flash_seq_pkg::MEM_AW-1:0]  rdAddr,
  output logic      [7:0]                        rdData
);

  logic [7:0] cells [0:(1<<flash_seq_pkg::MEM_AW)-1];

  // ----------------------------------------------------------------
  // no reset: cells are filled by the erase engine
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (wrEn) begin
      cells[wrAddr] <= wrData;
    end
    rdData <= cells[rdAddr];
  end

endmodule // flash_byte_mem

/* flash_sequencer.sv */
// flash_sequencer: link-side shifter plus system-side program/erase
// engine with busy flag, write-enable latch and wrap setting.
// assumes host drives select and link clock; data lines are inputs.
// Summary of operation
// (R1) single-line 77h, address-width dummies, then eight wrap bits captured
// (R2) four-byte address mode makes wrap instruction carry 32 dummies
// (R3) wrap bit 7 and bits 3..0 ignored; only bits 6..4 kept
// (R4) wrap_disable 0: length select 8/16/32/64 bytes; 1: no wrap
// (R5) wrap setting held for later quad reads until rewritten
// (R6) wrap_disable resets to 1; host rewrites it to leave wrap
// (R7) four-line mode uses 0Ch/C0h for wrap; setting stays valid (here 77h is ignored in four-line mode, 0Ch/C0h not decoded)
// (R8) page program 02h, address, one to 256 data bytes
// (R9) program/erase accepted only while write-enable latch is 1
// (R10) program address increments low eight bits, wraps inside page
// (R11) partial page program leaves the other page bytes unchanged
// (R12) select must rise right after a whole byte, else discarded
// (R13) self-timed cycle holds busy high, status readable throughout
// (R14) write-enable latch cleared when program or erase completes
// (R15) protected addresses are never programmed or erased
// (R16) quad program 32h needs quad_io_enable and write enable
// (R17) quad program exists only in single-line command mode
// (R18) sector erase 20h sets addressed 4 KB sector to FFh
// (R19) small block erase 52h sets addressed 32 KB block to ones
// (R20) large block erase D8h sets addressed 64 KB block to ones
// (R21) four-byte mode uses 32-bit addresses, else 24-bit
// (R22) bits shift msb first on rising link clock, nibble in quad
// (R23) programming only clears bits; erased cells read all ones
module flash_sequencer #(
  parameter int PROG_CYC = flash_seq_pkg::PROG_CYCLES,
  parameter int SECT_CYC = flash_seq_pkg::SECT_CYCLES,
  parameter int SBLK_CYC = flash_seq_pkg::SBLK_CYCLES,
  parameter int LBLK_CYC = flash_seq_pkg::LBLK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        linkClock,
  input  wire logic        chipSelect_n,
  input  wire logic [3:0]  quadLines,
  input  wire logic        fourByteMode,
  input  wire logic        fourLineCommandMode,
  input  wire logic        quadIoEnable,
  input  wire logic        writeEnableSet,
  input  wire logic        protectHit,
  input  wire logic [flash_seq_pkg::MEM_AW-1:0] readAddr,
  output logic      [7:0]  readData,
  output logic      [31:0] protectQueryAddr,
  output logic             busy,
  output logic             writeEnableLatch,
  output logic             wrapDisable,
  output logic      [1:0]  wrapLengthSel,
  output logic             cmdDone
);

  // ----------------------------------------------------------------
  // link domain: shift register and frame capture
  // ----------------------------------------------------------------
  logic [7:0]  opcodeL_r;
  logic [31:0] addrL_r;
  logic [7:0]  byteL_r;
  logic [11:0] bitCntL_r;
  logic [8:0]  pageIdxL_r;
  logic [7:0]  pageBufL_r [0:flash_seq_pkg::PAGE_BYTES-1];
  logic [8:0]  byteCntL_r;
  logic        byteAlignedL_r;
  logic        frameTogL_r;
  logic [11:0] frameBitsL_r;
  logic        frameAlignedL_r;
  logic        isQuadL;
  logic [3:0]  stepL;
  logic [11:0] addrBitsL;
  logic [11:0] hdrBitsL;
  logic [11:0] bitNxtL;
  logic [7:0]  shiftNxtL;
  logic        byteEndL;

  assign isQuadL   = (opcodeL_r == flash_seq_pkg::OP_QUAD_PROG)
                   && (bitCntL_r >= hdrBitsL);            // [R16]
  assign stepL     = isQuadL ? 4'h4 : 4'h1;               // [R22]
  assign addrBitsL = fourByteMode ? 12'h020 : 12'h018;    // [R2] [R21]
  assign hdrBitsL  = 12'h008 + addrBitsL;
  assign bitNxtL   = bitCntL_r + 12'(stepL);
  assign shiftNxtL = isQuadL ? {byteL_r[3:0], quadLines}
                             : {byteL_r[6:0], quadLines[0]}; // [R22]
  assign byteEndL  = (bitNxtL[2:0] == 3'h0);

  always_ff @(posedge linkClock or posedge chipSelect_n) begin
    if (chipSelect_n) begin
      bitCntL_r      <= 12'h000;
      byteAlignedL_r <= 1'b0;
    end else begin
      bitCntL_r      <= bitNxtL;
      byteAlignedL_r <= byteEndL;                         // [R12]
    end
  end

  // opcode and address shift in msb first
  always_ff @(posedge linkClock) begin
    byteL_r <= shiftNxtL;                                 // [R22]
    if (bitCntL_r < 12'h008) begin
      opcodeL_r <= {opcodeL_r[6:0], quadLines[0]};
    end else if (bitCntL_r < hdrBitsL) begin
      addrL_r <= {addrL_r[30:0], quadLines[0]};           // [R21]
    end
    if (bitCntL_r < hdrBitsL) begin
      byteCntL_r <= 9'h000;
      pageIdxL_r <= 9'h000;
    end else if (byteEndL) begin
      pageBufL_r[pageIdxL_r[7:0]] <= shiftNxtL;
      pageIdxL_r <= {1'b0, pageIdxL_r[7:0] + 8'h01};
      byteCntL_r <= (byteCntL_r == 9'h100) ? byteCntL_r
                                           : byteCntL_r + 9'h001;
    end
  end

  // frame end: select rising is the link-side event source
  // counter is cleared by this same edge, so its length is kept here
  always_ff @(posedge chipSelect_n or negedge reset_n) begin
    if (!reset_n) begin
      frameTogL_r     <= 1'b0;
      frameBitsL_r    <= 12'h000;
      frameAlignedL_r <= 1'b0;
    end else begin
      frameTogL_r     <= ~frameTogL_r;
      frameBitsL_r    <= bitCntL_r;
      frameAlignedL_r <= byteAlignedL_r;                  // [R12]
    end
  end

  // ----------------------------------------------------------------
  // crossing: three-stage sync of frame toggle
  // ----------------------------------------------------------------
  logic [2:0] frameSync_r;
  logic       frameEvent;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      frameSync_r <= 3'h0;
    end else begin
      frameSync_r <= {frameSync_r[1:0], frameTogL_r};
    end
  end
  assign frameEvent = frameSync_r[2] ^ frameSync_r[1];

  // frame fields are stable from select rise until next select fall;
  // host keeps select high longer than the sync latency.

  // ----------------------------------------------------------------
  // decode of the captured frame
  // ----------------------------------------------------------------
  function automatic logic [31:0] erase_base(input logic [31:0] a,
                                             input logic [31:0] mask);
    erase_base = a & ~mask;
  endfunction

  logic [31:0]             frameAddr;
  flash_seq_pkg::cmd_type  frameCmd;
  logic                    headerOk;
  logic                    wrapOk;
  logic                    dataOk;
  logic                    accept;

  assign frameAddr = fourByteMode ? addrL_r : {8'h00, addrL_r[23:0]};
  assign headerOk  = frameAlignedL_r && (frameBitsL_r >= hdrBitsL);
  assign wrapOk    = frameAlignedL_r
                   && (frameBitsL_r == hdrBitsL + 12'h008); // [R1] [R12]
  assign dataOk    = headerOk && (frameBitsL_r > hdrBitsL); // [R8]

  always_comb begin
    case (opcodeL_r)
      flash_seq_pkg::OP_SET_WRAP:
        frameCmd = fourLineCommandMode ? flash_seq_pkg::CMD_NONE
                                       : flash_seq_pkg::CMD_WRAP; // [R7]
      flash_seq_pkg::OP_PAGE_PROG:  frameCmd = flash_seq_pkg::CMD_PROG;
      flash_seq_pkg::OP_QUAD_PROG:
        frameCmd = (fourLineCommandMode || !quadIoEnable)
                 ? flash_seq_pkg::CMD_NONE
                 : flash_seq_pkg::CMD_QPROG;              // [R16] [R17]
      flash_seq_pkg::OP_SECTOR_ERS: frameCmd = flash_seq_pkg::CMD_SECT;
      flash_seq_pkg::OP_SMALL_ERS:  frameCmd = flash_seq_pkg::CMD_SBLK;
      flash_seq_pkg::OP_LARGE_ERS:  frameCmd = flash_seq_pkg::CMD_LBLK;
      default:                      frameCmd = flash_seq_pkg::CMD_NONE;
    endcase
  end

  logic isProg;
  logic isErase;
  logic [31:0] eraseMask;
  assign isProg  = (frameCmd == flash_seq_pkg::CMD_PROG)
                || (frameCmd == flash_seq_pkg::CMD_QPROG);
  assign isErase = (frameCmd == flash_seq_pkg::CMD_SECT)
                || (frameCmd == flash_seq_pkg::CMD_SBLK)
                || (frameCmd == flash_seq_pkg::CMD_LBLK);
  assign eraseMask = (frameCmd == flash_seq_pkg::CMD_SECT) ? 32'h0000_0fff
                   : (frameCmd == flash_seq_pkg::CMD_SBLK) ? 32'h0000_7fff
                   : 32'h0000_ffff;                        // [R18] [R19] [R20]
  assign protectQueryAddr = frameAddr;
  assign accept = frameEvent && !busy && writeEnableLatch && !protectHit
               && ((isProg && dataOk) || (isErase && headerOk
                   && frameBitsL_r == hdrBitsL));         // [R9] [R12] [R15]

  // ----------------------------------------------------------------
  // system domain: engine state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_WORK} eng_type;
  eng_type     state_r;
  logic [31:0] timer_r;
  logic [31:0] cur_r;
  logic [31:0] last_r;
  logic        doProg_r;
  logic [8:0]  progLeft_r;
  logic [7:0]  progIdx_r;
  logic        wel_r;
  logic [2:0]  wrap_r;
  logic        memWr;
  logic [7:0]  memWrData;
  logic [7:0]  memRd;
  logic [7:0]  progByte;

  assign progByte  = pageBufL_r[progIdx_r];
  // partial program touches only addressed bytes
  assign memWr     = (state_r == ST_WORK);                // [R11]
  assign memWrData = doProg_r ? (memRd & progByte)
                              : flash_seq_pkg::ERASED_BYTE; // [R23]

  flash_byte_mem u_mem (
    .clock  (clock),
    .wrEn   (memWr),
    .wrAddr (cur_r[flash_seq_pkg::MEM_AW-1:0]),
    .wrData (memWrData),
    // engine cell is read in its wait cycle, ahead of the write
    .rdAddr (busy ? cur_r[flash_seq_pkg::MEM_AW-1:0] : readAddr),
    .rdData (memRd)
  );
  assign readData = memRd;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r    <= ST_IDLE;
      timer_r    <= 32'h0;
      cur_r      <= 32'h0;
      last_r     <= 32'h0;
      doProg_r   <= 1'b0;
      progLeft_r <= 9'h0;
      progIdx_r  <= 8'h0;
    end else begin
      case (state_r)
        ST_IDLE: if (accept) begin
          state_r  <= ST_WAIT;                            // [R13]
          doProg_r <= isProg;
          progLeft_r <= byteCntL_r;
          progIdx_r  <= 8'h00;
          cur_r    <= isProg ? frameAddr
                             : erase_base(frameAddr, eraseMask);
          last_r   <= erase_base(frameAddr, eraseMask) | eraseMask;
          timer_r  <= isProg ? 32'(PROG_CYC)
                    : (frameCmd == flash_seq_pkg::CMD_SECT) ? 32'(SECT_CYC)
                    : (frameCmd == flash_seq_pkg::CMD_SBLK) ? 32'(SBLK_CYC)
                    : 32'(LBLK_CYC);
        end
        ST_WAIT: begin
          state_r <= ST_WORK;  // one cycle so read data is valid
        end
        ST_WORK: begin
          timer_r <= (timer_r == 32'h0) ? 32'h0 : timer_r - 32'h1;
          if (doProg_r) begin
            // only low eight address bits advance
            cur_r      <= {cur_r[31:8], cur_r[7:0] + 8'h01}; // [R10]
            progIdx_r  <= progIdx_r + 8'h01;
            progLeft_r <= progLeft_r - 9'h001;
            state_r    <= (progLeft_r == 9'h001) ? ST_IDLE : ST_WAIT;
          end else begin
            cur_r   <= cur_r + 32'h1;
            state_r <= (cur_r == last_r) ? ST_IDLE : ST_WAIT;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
  // limitation: the cycle ends when the cells are done, timer counts down
  // but paces nothing; the modelled array only covers the low address bits.

  assign busy    = (state_r != ST_IDLE);                  // [R13]
  assign cmdDone = (state_r == ST_WORK) && (doProg_r
                 ? (progLeft_r == 9'h001) : (cur_r == last_r));

  // ----------------------------------------------------------------
  // write-enable latch and wrap setting
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wel_r <= 1'b0;
    end else if (cmdDone) begin
      wel_r <= 1'b0;                                      // [R14]
    end else if (writeEnableSet && !busy) begin
      wel_r <= 1'b1;                                      // [R9]
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wrap_r <= flash_seq_pkg::WRAP_RESET;                // [R6]
    end else if (frameEvent && !busy && wrapOk
                 && frameCmd == flash_seq_pkg::CMD_WRAP) begin
      // bits 7 and 3..0 dropped
      wrap_r <= {byteL_r[flash_seq_pkg::WRAP_LEN_HI:
                         flash_seq_pkg::WRAP_LEN_LO],
                 byteL_r[flash_seq_pkg::WRAP_DIS_BIT]};   // [R1] [R3] [R5]
    end
  end

  assign writeEnableLatch = wel_r;
  assign wrapDisable      = wrap_r[0];                    // [R4]
  assign wrapLengthSel    = wrap_r[2:1];                  // [R4]

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_busy_starts: assert property (                          // [R13]
    @(posedge clock) disable iff (!reset_n)
    accept |=> busy
  ) else $error("busy not raised");
  a_wel_needed: assert property (                           // [R9]
    @(posedge clock) disable iff (!reset_n)
    (!busy && !$past(writeEnableLatch) && !writeEnableLatch) |=> !busy
  ) else $error("cycle started without latch");
  a_wel_cleared: assert property (                          // [R14]
    @(posedge clock) disable iff (!reset_n)
    cmdDone |=> !writeEnableLatch && !busy
  ) else $error("latch kept");
  a_protect_block: assert property (                        // [R15]
    @(posedge clock) disable iff (!reset_n)
    (state_r == ST_IDLE && protectHit) |=> !busy
  ) else $error("protected cycle ran");
  a_wrap_stable: assert property (                          // [R5]
    @(posedge clock) disable iff (!reset_n)
    !frameEvent |=> $stable(wrap_r)
  ) else $error("wrap changed");
  a_prog_page: assert property (                            // [R10]
    @(posedge clock) disable iff (!reset_n)
    (state_r == ST_WORK && doProg_r) |=> $stable(cur_r[31:8])
  ) else $error("page crossed");
  a_erase_ones: assert property (                           // [R18]
    @(posedge clock) disable iff (!reset_n)
    (memWr && !doProg_r) |-> memWrData == flash_seq_pkg::ERASED_BYTE
      && (last_r - cur_r) <= 32'h0000_ffff
  ) else $error("erase outside block");
  a_prog_clear: assert property (                           // [R23]
    @(posedge clock) disable iff (!reset_n)
    (memWr && doProg_r) |-> (memWrData & ~memRd) == 8'h00
  ) else $error("bit set by program");

  c_prog: cover property (@(posedge clock) disable iff (!reset_n)
    accept && isProg);
  c_erase: cover property (@(posedge clock) disable iff (!reset_n)
    accept && isErase);
  c_wrap: cover property (@(posedge clock) disable iff (!reset_n)
    frameEvent && wrapOk);

endmodule // flash_sequencer

/* host_link_model.sv */
// host_link_model: host side of the serial link to the sequencer.
// assumes the bench calls frame() one at a time, never overlapping.
module host_link_model (
  output logic       linkClock,
  output logic       chipSelect_n,
  output logic [3:0] quadLines
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    linkClock = 1'b0;
    chipSelect_n = 1'b1;
    quadLines = 4'h5;
  end

  // ---------------------------------------------------------------
  // link timing
  // ---------------------------------------------------------------
  // data changes after the falling edge, sampled on the rise
  task automatic put(input logic [3:0] v);
    quadLines = v;
    #24 linkClock = 1'b1;
    #24 linkClock = 1'b0;
  endtask

  // bytes before quadFrom go msb first on line 0, the rest as
  // nibbles on all four lines extraBits breaks the
  // byte boundary on purpose
  task automatic frame(input logic [7:0] b[$], input int quadFrom,
                       input int extraBits);
    chipSelect_n = 1'b0;
    foreach (b[i]) begin
      if (i >= quadFrom) begin
        put(b[i][7:4]);
        put(b[i][3:0]);
      end else begin
        for (int k = 7; k >= 0; k--) put({~quadLines[3:1], b[i][k]});
      end
    end
    repeat (extraBits) put(4'h1);
    #24 chipSelect_n = 1'b1;  // bytes and any extra bits, then release
    quadLines = ~quadLines;  // released lines never hold the last value
  endtask
endmodule // host_link_model

/* testbench.sv */
// testbench: wrap setting, program, erase and refusals of the sequencer.
// assumes the 4K-byte array model and a 2-clock-per-cell cycle.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        fourByteMode = 1'b0;
  logic        fourLineCommandMode = 1'b0;
  logic        quadIoEnable = 1'b0;
  logic        writeEnableSet = 1'b0;
  logic        protectHit = 1'b0;
  logic [flash_seq_pkg::MEM_AW-1:0] readAddr = '0;
  logic        linkClock, chipSelect_n, busy, writeEnableLatch, cmdDone;
  logic        wrapDisable;
  logic [3:0]  quadLines;
  logic [7:0]  readData, w;
  logic [1:0]  wrapLengthSel;
  logic [31:0] protectQueryAddr;
  logic [7:0]  mem [4096];
  logic [7:0]  bq[$];
  logic        notes[$];
  int          failures = 0;
  int          n_checks = 0;

  always #5 clock = ~clock;

  flash_sequencer flash_sequencer_inst (.clock(clock), .reset_n(reset_n),
    .linkClock(linkClock), .chipSelect_n(chipSelect_n),
    .quadLines(quadLines), .fourByteMode(fourByteMode),
    .fourLineCommandMode(fourLineCommandMode),
    .quadIoEnable(quadIoEnable), .writeEnableSet(writeEnableSet),
    .protectHit(protectHit), .readAddr(readAddr), .readData(readData),
    .protectQueryAddr(protectQueryAddr), .busy(busy),
    .writeEnableLatch(writeEnableLatch),
    .wrapDisable(wrapDisable), .wrapLengthSel(wrapLengthSel),
    .cmdDone(cmdDone));

  host_link_model host_link_model_inst (.linkClock(linkClock),
    .chipSelect_n(chipSelect_n), .quadLines(quadLines));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // opcode then 24- or 32-bit address
  task automatic head(input logic [7:0] op, input logic [31:0] a);
    bq = {op};
    if (fourByteMode) bq.push_back(a[31:24]);
    bq.push_back(a[23:16]);
    bq.push_back(a[15:8]);
    bq.push_back(a[7:0]);
  endtask

  task automatic prog(input logic [11:0] a, input int n);
    logic [7:0] d;
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom);
      bq.push_back(d);
      mem[{a[11:8], a[7:0] + 8'(k)}] &= d;
    end
  endtask

  // optional latch set, frame, then wait out any self-timed cycle
  task automatic op(input bit write_enable_latch, input bit ok, input int qf,
                    input int xb);
    int i;
    if (write_enable_latch) begin
      writeEnableSet = 1'b1;
      tick(1);
      writeEnableSet = 1'b0;
      tick(1);
      check(writeEnableLatch, 1'b1);
    end
    if (ok) notes.push_back(1'b1);
    host_link_model_inst.frame(bq, qf, xb);
    for (i = 0; i < 20 && busy !== 1'b1; i++) tick(1);
    check(busy, ok);
    for (i = 0; i < 20000 && busy === 1'b1; i++) tick(1);
    tick(2);
    check(writeEnableLatch, write_enable_latch & !ok);
  endtask

  task automatic rd(input logic [11:0] a);
    readAddr = a;
    tick(2);
    check(readData, mem[a]);
  endtask

  // each finished cycle must match a note left by an accepted frame
  always @(negedge clock) begin
    if (cmdDone === 1'b1) begin
      if (notes.size() == 0) check(1'b0, 1'b1);
      else check(busy, notes.pop_front());
    end
  end

  initial begin
    #400us;
    failures++;
    results();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h917f));
    tick(16);
    reset_n = 1'b1;
    tick(2);
    check(wrapDisable, 1'b1);
    check({busy, writeEnableLatch, wrapLengthSel}, 4'h0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      fourByteMode = i[0];
      w = 8'($urandom);
      w[6:4] = i[2:0];
      head(flash_seq_pkg::OP_SET_WRAP, 32'h0);
      bq.push_back(w);
      op(1'b0, 1'b0, 99, 0);
      check(wrapDisable, w[4]);
      check(wrapLengthSel, w[6:5]);
    end
    fourLineCommandMode = 1'b1;
    head(flash_seq_pkg::OP_SET_WRAP, 32'h0);
    bq.push_back(8'h00);
    op(1'b0, 1'b0, 99, 0);
    check({wrapLengthSel, wrapDisable}, w[6:4]);
    fourLineCommandMode = 1'b0;
    fourByteMode = 1'b0;
    $display("test wrap done");
    head(flash_seq_pkg::OP_SECTOR_ERS, 32'h0);
    op(1'b1, 1'b1, 99, 0);
    foreach (mem[k]) mem[k] = 8'hff;
    rd(12'h7c3);
    head(flash_seq_pkg::OP_PAGE_PROG, 32'h1fe);
    prog(12'h1fe, 4);
    op(1'b1, 1'b1, 99, 0);
    fourByteMode = 1'b1;
    quadIoEnable = 1'b1;
    head(flash_seq_pkg::OP_QUAD_PROG, 32'h100);
    prog(12'h100, 2);
    op(1'b1, 1'b1, 5, 0);
    fourByteMode = 1'b0;
    for (int a = 12'h1fd; a < 12'h203; a++) rd(12'(a));
    rd(12'h100);
    $display("test program done");
    for (int c = 0; c < 7; c++) begin
      protectHit = (c == 2 || c == 3);
      fourLineCommandMode = (c == 4);
      quadIoEnable = (c != 6);
      case (c)
        2: head(flash_seq_pkg::OP_SMALL_ERS, 32'h0);
        3: head(flash_seq_pkg::OP_LARGE_ERS, 32'h0);
        4, 6: head(flash_seq_pkg::OP_QUAD_PROG, 32'h300);
        default: head(flash_seq_pkg::OP_PAGE_PROG, 32'h300);
      endcase
      if (c != 2 && c != 3 && c != 5) bq.push_back(8'h00);
      op(c != 0, 1'b0, (c == 4 || c == 6) ? 4 : 99,
         (c == 1) ? 3 : 0);
    end
    rd(12'h300);
    rd(12'h000);
    check({wrapLengthSel, wrapDisable}, w[6:4]);
    check(protectQueryAddr, 32'h300);
    check(notes.size(), 32'h0);
    $display("test refusals done");
    results();
  end
endmodule // testbench
